// ---- rtl/msi_pm_cap_pkg.sv ----
// constants and carriers for the message interrupt and power management capability bank
// assumes a single clock domain and a 32-bit AHB-Lite register bus
package msi_pm_cap_pkg;
  // register indices; byte address is four times the index
  localparam logic [9:0] IDX_MSI_IDENT = 10'h05c;
  localparam logic [9:0] IDX_MSI_NEXT = 10'h05d;
  localparam logic [9:0] IDX_MSI_CONTROL = 10'h05e;
  localparam logic [9:0] IDX_MSI_ADDR_LO = 10'h060;
  localparam logic [9:0] IDX_MSI_ADDR_HI = 10'h064;
  localparam logic [9:0] IDX_MSI_PAYLOAD = 10'h068;
  localparam logic [9:0] IDX_PM_CAP = 10'h06c;
  localparam logic [9:0] IDX_IRQ_STATUS = 10'h080;
  localparam logic [9:0] IDX_IRQ_MASK = 10'h081;

  // fixed identifiers and pointers
  localparam logic [7:0] MSI_IDENT_VAL = 8'h05;
  localparam logic [7:0] MSI_NEXT_VAL = 8'h6c;
  localparam logic [15:0] MSI_CONTROL_RST = 16'h0080;
  localparam logic [4:0] WAKE_SUPPORT_VAL = 5'h19;
  localparam logic [2:0] PM_REVISION_VAL = 3'h2;
  localparam logic [7:0] PM_LINK_HP_ON = 8'h78;
  localparam logic [7:0] PM_LINK_HP_OFF = 8'hd8;
  localparam logic [7:0] PM_IDENT_VAL = 8'h01;

  // message control field positions
  localparam int CTL_WIDE_BIT = 7;
  localparam int CTL_MVE_LSB = 4;
  localparam int CTL_MVC_LSB = 1;
  localparam int CTL_EN_BIT = 0;
  localparam int SLOT_HP_ENABLE_BIT = 3;

  // interrupt status bits
  localparam int IRQ_W = 2;
  localparam int IRQ_MSG_SENT = 0;
  localparam int IRQ_WIRED_EVENT = 1;

  typedef struct packed {
    logic [63:0] addr;
    logic [31:0] data;
  } msi_write_t;

  typedef struct packed {
    logic write;
    logic [9:0] index;
  } bus_cmd_t;
endpackage

// ---- rtl/msi_pm_cap_regs.sv ----
// message interrupt and power management capability registers behind an AHB-Lite slave
// assumes i_msi_ack answers o_msi_req once per write; slot config is stable during use
//
// Behaviour
// - message capability identifier reads 05h
// - message next pointer reads 6Ch
// - wide address capable bit reads one
// - multi vector enable stored; one message only
// - multi vector capable reads zero
// - message enabled: no wired interrupt
// - message disabled: no message writes, wired instead
// - low address bits 31:2 stored, 1:0 zero
// - high address bits 31:2 stored, 1:0 zero
// - payload placed on low data word
// - wake support field reads 19h
// - state one and two support read zero
// - aux current field reads zero
// - device specific init bit reads zero
// - wake clock bit reads zero
// - revision field reads 02h
// - pm chain link 78h or D8h by slot
// - pm capability identifier reads 01h
//
// Decided for this implementation: register access over AHB-Lite.
`timescale 1ns/1ps
module msi_pm_cap_regs
  import msi_pm_cap_pkg::*;
#(
  parameter int HADDR_W = 32
) (
  input wire logic i_clock,
  input wire logic i_nrst,
  input wire logic i_hsel,
  input wire logic [HADDR_W-1:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [2:0] i_hsize,
  input wire logic [31:0] i_hwdata,
  input wire logic i_hready,
  output logic [31:0] o_hrdata,
  output logic o_hreadyout,
  output logic o_hresp,
  input wire logic [7:0] i_slot_config,
  input wire logic i_hp_event,
  input wire logic i_hp_pending,
  output logic o_wired_irq,
  output logic o_msi_req,
  output msi_write_t o_msi_write,
  input wire logic i_msi_ack,
  output logic o_irq
);

  // the hit test needs at least one address bit above the register map
  if (HADDR_W < 13) begin : g_width_check
    $error("address bus too narrow for the register map");
  end

  typedef enum logic [0:0] {SEQ_IDLE, SEQ_SEND} seq_state_t;

  function automatic logic hits(input logic [HADDR_W-1:0] addr, input logic [9:0] idx);
    hits = (addr[11:2] == idx) && (addr[HADDR_W-1:12] == '0);
  endfunction

  logic accept;
  logic [2:0] mve_q;
  logic msi_en_q;
  logic [29:0] addr_lo_q;
  logic [29:0] addr_hi_q;
  logic [15:0] payload_q;
  logic [IRQ_W-1:0] status_q;
  logic [IRQ_W-1:0] mask_q;
  logic [IRQ_W-1:0] status_set;
  logic [IRQ_W-1:0] status_clr;
  logic [IRQ_W-1:0] mask_next;
  bus_cmd_t cmd_q;
  logic wr_q;
  logic rd_q;
  logic [31:0] rdata_d;
  logic [15:0] control_val;
  logic [31:0] pm_val;
  logic again_q;
  seq_state_t seq_q;

  assign accept = i_hsel && i_htrans[1] && i_hready;

  // bus phases: writes complete without wait, reads take one wait state so a
  // read just after a write sees the written value
  always_ff @(posedge i_clock) begin
    if (!i_nrst) begin
      cmd_q <= '0;
      wr_q <= 1'b0;
      rd_q <= 1'b0;
    end else begin
      wr_q <= accept && i_hwrite;
      rd_q <= accept && !i_hwrite;
      if (accept) begin
        cmd_q <= '{write: i_hwrite, index: i_haddr[11:2]};
      end
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_nrst) begin
      o_hreadyout <= 1'b1;
      o_hresp <= 1'b0;
      o_hrdata <= 32'h0000_0000;
    end else begin
      o_hresp <= 1'b0;
      o_hreadyout <= !(accept && !i_hwrite);
      if (rd_q) begin
        o_hrdata <= rdata_d;
      end
    end
  end

  assign control_val = {8'h00, 1'b1, mve_q, 3'b000, msi_en_q};

  assign pm_val = {WAKE_SUPPORT_VAL,
                   1'b0, 1'b0,
                   3'b000,
                   1'b0,
                   1'b0,
                   1'b0,
                   PM_REVISION_VAL,
                   i_slot_config[SLOT_HP_ENABLE_BIT] ? PM_LINK_HP_ON : PM_LINK_HP_OFF,
                   PM_IDENT_VAL};

  always_comb begin
    rdata_d = 32'h0000_0000;
    unique case (cmd_q.index)
      IDX_MSI_IDENT: rdata_d = {24'h00_0000, MSI_IDENT_VAL};
      IDX_MSI_NEXT: rdata_d = {24'h00_0000, MSI_NEXT_VAL};
      IDX_MSI_CONTROL: rdata_d = {16'h0000, control_val};
      IDX_MSI_ADDR_LO: rdata_d = {addr_lo_q, 2'b00};
      IDX_MSI_ADDR_HI: rdata_d = {addr_hi_q, 2'b00};
      IDX_MSI_PAYLOAD: rdata_d = {16'h0000, payload_q};
      IDX_PM_CAP: rdata_d = pm_val;
      IDX_IRQ_STATUS: rdata_d = {{(32-IRQ_W){1'b0}}, status_q};
      IDX_IRQ_MASK: rdata_d = {{(32-IRQ_W){1'b0}}, mask_q};
      default: rdata_d = 32'h0000_0000;
    endcase
  end

  // software-owned message configuration
  always_ff @(posedge i_clock) begin
    if (!i_nrst) begin
      mve_q <= MSI_CONTROL_RST[CTL_MVE_LSB +: 3];
      msi_en_q <= MSI_CONTROL_RST[CTL_EN_BIT];
      addr_lo_q <= 30'h0000_0000;
      addr_hi_q <= 30'h0000_0000;
      payload_q <= 16'h0000;
      mask_q <= '0;
    end else if (wr_q) begin
      unique case (cmd_q.index)
        IDX_MSI_CONTROL: begin
          mve_q <= i_hwdata[CTL_MVE_LSB +: 3];
          msi_en_q <= i_hwdata[CTL_EN_BIT];
        end
        IDX_MSI_ADDR_LO: addr_lo_q <= i_hwdata[31:2];
        IDX_MSI_ADDR_HI: addr_hi_q <= i_hwdata[31:2];
        IDX_MSI_PAYLOAD: payload_q <= i_hwdata[15:0];
        IDX_IRQ_MASK: mask_q <= i_hwdata[IRQ_W-1:0];
        default: ;
      endcase
    end
  end

  // message sequencer: one write per event; an event during a write is
  // remembered once, so a burst of events may merge into one more message
  always_ff @(posedge i_clock) begin
    if (!i_nrst) begin
      seq_q <= SEQ_IDLE;
      again_q <= 1'b0;
      o_msi_req <= 1'b0;
      o_msi_write <= '0;
    end else if (!msi_en_q) begin
      seq_q <= SEQ_IDLE;
      again_q <= 1'b0;
      o_msi_req <= 1'b0;
    end else begin
      unique case (seq_q)
        SEQ_IDLE: begin
          if (i_hp_event || again_q) begin
            seq_q <= SEQ_SEND;
            again_q <= 1'b0;
            o_msi_req <= 1'b1;
            o_msi_write.addr <= {addr_hi_q, 2'b00, addr_lo_q, 2'b00};
            o_msi_write.data <= {16'h0000, payload_q};
          end
        end
        SEQ_SEND: begin
          if (i_hp_event) begin
            again_q <= 1'b1;
          end
          if (i_msi_ack) begin
            seq_q <= SEQ_IDLE;
            o_msi_req <= 1'b0;
          end
        end
      endcase
    end
  end

  // wired line only serves while message signaling is off
  always_ff @(posedge i_clock) begin
    if (!i_nrst) begin
      o_wired_irq <= 1'b0;
    end else begin
      o_wired_irq <= i_hp_pending && !msi_en_q;
    end
  end

  always_comb begin
    status_set = '0;
    status_set[IRQ_MSG_SENT] = o_msi_req && i_msi_ack;
    status_set[IRQ_WIRED_EVENT] = i_hp_event && !msi_en_q;
    status_clr = (wr_q && cmd_q.index == IDX_IRQ_STATUS) ? i_hwdata[IRQ_W-1:0] : '0;
    // mask write acts on the level at the same edge that stores it
    mask_next = (wr_q && cmd_q.index == IDX_IRQ_MASK) ? i_hwdata[IRQ_W-1:0] : mask_q;
  end

  // set beats a simultaneous write-one-to-clear
  always_ff @(posedge i_clock) begin
    if (!i_nrst) begin
      status_q <= '0;
      o_irq <= 1'b0;
    end else begin
      status_q <= (status_q & ~status_clr) | status_set;
      o_irq <= |(((status_q & ~status_clr) | status_set) & mask_next);
    end
  end

  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (!i_nrst);

  sequence s_read(logic [9:0] idx);
    accept && !i_hwrite && hits(i_haddr, idx);
  endsequence

  sequence s_answer;
    !o_hreadyout ##1 o_hreadyout;
  endsequence

  property p_msi_ident;
    s_read(IDX_MSI_IDENT) |-> ##1 s_answer ##0 (o_hrdata == 32'h0000_0005);
  endproperty
  a_msi_ident: assert property (p_msi_ident) else $error("message identifier wrong");

  property p_next_ptr;
    s_read(IDX_MSI_NEXT) |-> ##1 s_answer ##0 (o_hrdata == 32'h0000_006c);
  endproperty
  a_next_ptr: assert property (p_next_ptr) else $error("message next pointer wrong");

  property p_control_fixed;
    s_read(IDX_MSI_CONTROL) |-> ##2 (o_hrdata[7] == 1'b1 && o_hrdata[3:1] == 3'b000
                                     && o_hrdata[31:8] == 24'h00_0000);
  endproperty
  a_control_fixed: assert property (p_control_fixed) else $error("control fixed bits wrong");

  property p_align;
    accept && !i_hwrite && (hits(i_haddr, IDX_MSI_ADDR_LO) || hits(i_haddr, IDX_MSI_ADDR_HI))
      |-> ##2 (o_hrdata[1:0] == 2'b00);
  endproperty
  a_align: assert property (p_align) else $error("address low bits not zero");

  property p_pm_cap;
    s_read(IDX_PM_CAP) ##0 i_slot_config[SLOT_HP_ENABLE_BIT] |->
      ##2 (o_hrdata == 32'hc802_7801);
  endproperty
  a_pm_cap: assert property (p_pm_cap) else $error("pm capability wrong with hot plug on");

  property p_pm_cap_off;
    s_read(IDX_PM_CAP) ##0 !i_slot_config[SLOT_HP_ENABLE_BIT] |->
      ##2 (o_hrdata == 32'hc802_d801);
  endproperty
  a_pm_cap_off: assert property (p_pm_cap_off) else $error("pm capability wrong, hot plug off");

  property p_no_wired;
    msi_en_q |=> !o_wired_irq;
  endproperty
  a_no_wired: assert property (p_no_wired) else $error("wired line while messages on");

  property p_no_msg;
    !msi_en_q |=> !o_msi_req;
  endproperty
  a_no_msg: assert property (p_no_msg) else $error("message while disabled");

  property p_event_msg;
    msi_en_q && seq_q == SEQ_IDLE && i_hp_event && !(wr_q && cmd_q.index == IDX_MSI_CONTROL)
      |=> o_msi_req && o_msi_write.data == {16'h0000, $past(payload_q)};
  endproperty
  a_event_msg: assert property (p_event_msg) else $error("event did not start message");

  property p_msg_hold;
    o_msi_req && !i_msi_ack && msi_en_q |=> o_msi_req && $stable(o_msi_write);
  endproperty
  a_msg_hold: assert property (p_msg_hold) else $error("message dropped before ack");

  // bus framing: writes never stall, reads stall exactly once
  sequence s_read_any;
    accept && !i_hwrite;
  endsequence

  sequence s_write_any;
    accept && i_hwrite;
  endsequence

  property p_read_wait;
    s_read_any |-> ##1 s_answer;
  endproperty
  a_read_wait: assert property (p_read_wait) else $error("read wait state wrong");

  property p_write_nowait;
    s_write_any |=> o_hreadyout;
  endproperty
  a_write_nowait: assert property (p_write_nowait) else $error("write stalled");

  property p_okay;
    !o_hresp;
  endproperty
  a_okay: assert property (p_okay) else $error("error response seen");

  // one command register serves both phases, so its direction must match
  property p_cmd_write;
    wr_q |-> cmd_q.write;
  endproperty
  a_cmd_write: assert property (p_cmd_write) else $error("command not a write");

  property p_cmd_read;
    rd_q |-> !cmd_q.write;
  endproperty
  a_cmd_read: assert property (p_cmd_read) else $error("command not a read");

  property p_payload_read;
    s_read(IDX_MSI_PAYLOAD) |-> ##1 s_answer ##0 (o_hrdata[31:16] == 16'h0000);
  endproperty
  a_payload_read: assert property (p_payload_read) else $error("payload high half set");

  property p_mask_read;
    s_read(IDX_IRQ_MASK) |-> ##1 s_answer ##0 (o_hrdata[31:IRQ_W] == '0);
  endproperty
  a_mask_read: assert property (p_mask_read) else $error("mask unused bits set");

  property p_msg_word;
    o_msi_req |-> o_msi_write.data[31:16] == 16'h0000;
  endproperty
  a_msg_word: assert property (p_msg_word) else $error("message data upper word set");

  // whatever the multi vector setting, the payload goes out untouched
  property p_single_vector;
    $rose(o_msi_req) |-> o_msi_write.data[15:0] == $past(payload_q);
  endproperty
  a_single_vector: assert property (p_single_vector) else $error("vector bits in data");

  property p_msg_align;
    o_msi_req |-> o_msi_write.addr[33:32] == 2'b00 && o_msi_write.addr[1:0] == 2'b00;
  endproperty
  a_msg_align: assert property (p_msg_align) else $error("message address not aligned");

  property p_ack_ends;
    o_msi_req && i_msi_ack |=> !o_msi_req;
  endproperty
  a_ack_ends: assert property (p_ack_ends) else $error("request held after ack");

  property p_seq_off;
    !msi_en_q |=> seq_q == SEQ_IDLE;
  endproperty
  a_seq_off: assert property (p_seq_off) else $error("sequencer busy while disabled");

  property p_wired_follow;
    !msi_en_q && i_hp_pending |=> o_wired_irq;
  endproperty
  a_wired_follow: assert property (p_wired_follow) else $error("wired line missing");

  // status and interrupt level
  property p_set_wins;
    (status_set != '0) |=> (status_q & $past(status_set)) == $past(status_set);
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("status event lost");

  property p_irq_level;
    o_irq == |(status_q & mask_q);
  endproperty
  a_irq_level: assert property (p_irq_level) else $error("interrupt level wrong");
endmodule

// ---- testbench/msi_host_model.sv ----
// host side of the message write port: takes each write and acks it
// assumes the requester holds req and the write struct until the ack pulse
`timescale 1ns/1ps
module msi_host_model (
  input wire logic i_clock,
  input wire logic i_nrst,
  input wire logic i_req,
  input wire logic i_slow,
  output logic o_ack
);
  logic [3:0] wait_q;

  // one ack per request; slow mode lets events pile up behind a busy write
  always_ff @(posedge i_clock) begin
    if (!i_nrst || !i_req || o_ack) begin
      wait_q <= 4'h0;
      o_ack <= 1'b0;
    end else if (wait_q >= (i_slow ? 4'h7 : 4'h0)) begin
      o_ack <= 1'b1;
    end else begin
      wait_q <= wait_q + 4'h1;
    end
  end
endmodule

// ---- testbench/tb_msi_pm_cap_regs.sv ----
// self-checking bench for the capability register bank and its message writes
// assumes one AHB-Lite slave, so the slave's hreadyout is fed back as hready
`timescale 1ns/1ps
module tb_msi_pm_cap_regs;
  import msi_pm_cap_pkg::*;
  logic i_clock, i_nrst, i_hsel, i_hwrite, i_hp_event, i_hp_pending, slow, rpend;
  logic [31:0] i_haddr, i_hwdata, o_hrdata, lo, hi, pay;
  logic [1:0] i_htrans;
  logic [7:0] i_slot_config;
  logic o_hreadyout, o_hresp, o_wired_irq, o_msi_req, i_msi_ack, o_irq;
  msi_write_t o_msi_write;
  logic [95:0] exp_q[$], msi_q[$];
  int err_total, checks;

  msi_pm_cap_regs msi_pm_cap_regs_i (.i_clock(i_clock), .i_nrst(i_nrst), .i_hsel(i_hsel),
    .i_haddr(i_haddr), .i_htrans(i_htrans), .i_hwrite(i_hwrite), .i_hsize(3'h2),
    .i_hwdata(i_hwdata), .i_hready(o_hreadyout), .o_hrdata(o_hrdata),
    .o_hreadyout(o_hreadyout), .o_hresp(o_hresp), .i_slot_config(i_slot_config),
    .i_hp_event(i_hp_event), .i_hp_pending(i_hp_pending), .o_wired_irq(o_wired_irq),
    .o_msi_req(o_msi_req), .o_msi_write(o_msi_write), .i_msi_ack(i_msi_ack), .o_irq(o_irq));
  msi_host_model msi_host_model_i (.i_clock(i_clock), .i_nrst(i_nrst), .i_req(o_msi_req),
    .i_slow(slow), .o_ack(i_msi_ack));

  initial begin
    i_clock = 1'b0;
    forever #5 i_clock = ~i_clock;
  end

  task automatic chk(input logic [95:0] seen, input logic [95:0] want);
    checks++;
    if (seen !== want) begin
      $display("CHECK FAILED at %0t: got %h want %h", $time, seen, want);
      err_total++;
    end
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // address phase held until hready, then data phase held until hready
  task automatic xfer(input logic [9:0] idx, input logic w, input logic [31:0] d);
    i_hsel <= 1'b1;
    i_haddr <= {20'h0_0000, idx, 2'b00};
    i_hwrite <= w;
    i_htrans <= 2'h2;
    do @(posedge i_clock); while (o_hreadyout !== 1'b1);
    i_htrans <= 2'h0;
    i_hwdata <= d;
    do @(posedge i_clock); while (o_hreadyout !== 1'b1);
  endtask

  task automatic rd(input logic [9:0] idx, input logic [31:0] e);
    exp_q.push_back({64'h0, e});
    xfer(idx, 1'b0, 32'h0000_0000);
  endtask

  task automatic ev();
    i_hp_event <= 1'b1;
    @(posedge i_clock);
    i_hp_event <= 1'b0;
    @(posedge i_clock);
  endtask

  task automatic drain();
    for (int n = 0; n < 80 && msi_q.size() != 0; n++) @(posedge i_clock);
    @(posedge i_clock);
  endtask

  // oldest note is taken when a read data phase or a message write completes
  always @(posedge i_clock) begin
    if (!i_nrst) rpend = 1'b0;
    if (rpend && o_hreadyout) begin
      chk({64'h0, o_hrdata}, exp_q.pop_front());
      rpend = 1'b0;
    end
    if (i_hsel && i_htrans[1] && o_hreadyout && !i_hwrite) rpend = 1'b1;
    if (o_msi_req && i_msi_ack) begin
      if (msi_q.size() == 0) chk(96'h1, 96'h0);
      else chk(o_msi_write, msi_q.pop_front());
    end
  end

  initial begin
    #200_000;
    err_total++;
    final_report();
  end

  initial begin
    {i_nrst, i_hsel, i_hwrite, i_hp_event, i_hp_pending, slow} = 6'h00;
    {i_haddr, i_hwdata, i_htrans} = 66'h0;
    i_slot_config = 8'h08;
    err_total = 0;
    checks = 0;
    void'($urandom(63293));
    repeat (10) @(posedge i_clock);
    i_nrst <= 1'b1;
    @(posedge i_clock);
    rd(IDX_MSI_IDENT, 32'h0000_0005);
    rd(IDX_MSI_NEXT, 32'h0000_006c);
    rd(IDX_MSI_CONTROL, 32'h0000_0080);
    rd(IDX_MSI_ADDR_LO, 32'h0000_0000);
    rd(IDX_MSI_ADDR_HI, 32'h0000_0000);
    rd(IDX_PM_CAP, 32'hc802_7801);
    rd(10'h3ff, 32'h0000_0000);
    $display("test reset values done");
    lo = $urandom;
    hi = $urandom;
    pay = $urandom;
    wr_all: begin
      xfer(IDX_MSI_CONTROL, 1'b1, 32'hffff_fffe);
      rd(IDX_MSI_CONTROL, 32'h0000_00f0);
      xfer(IDX_MSI_ADDR_LO, 1'b1, lo);
      xfer(IDX_MSI_ADDR_HI, 1'b1, hi);
      xfer(IDX_MSI_PAYLOAD, 1'b1, pay);
      rd(IDX_MSI_ADDR_LO, lo & 32'hffff_fffc);
      rd(IDX_MSI_ADDR_HI, hi & 32'hffff_fffc);
      rd(IDX_MSI_PAYLOAD, {16'h0000, pay[15:0]});
      xfer(IDX_PM_CAP, 1'b1, 32'h0000_0000);
      i_slot_config <= 8'hf7;
      rd(IDX_PM_CAP, 32'hc802_d801);
    end
    $display("test register access done");
    xfer(IDX_IRQ_MASK, 1'b1, 32'h0000_0003);
    i_hp_pending <= 1'b1;
    ev();
    ev();
    chk(o_wired_irq, 1'b1);
    chk(o_irq, 1'b1);
    rd(IDX_IRQ_STATUS, 32'h0000_0002);
    xfer(IDX_IRQ_STATUS, 1'b1, 32'h0000_0002);
    rd(IDX_IRQ_STATUS, 32'h0000_0000);
    chk(o_irq, 1'b0);
    $display("test wired fallback done");
    xfer(IDX_MSI_CONTROL, 1'b1, 32'h0000_0001);
    msi_q.push_back({hi & 32'hffff_fffc, lo & 32'hffff_fffc, 16'h0000, pay[15:0]});
    ev();
    drain();
    chk(o_wired_irq, 1'b0);
    chk(o_irq, 1'b1);
    rd(IDX_IRQ_STATUS, 32'h0000_0001);
    xfer(IDX_IRQ_STATUS, 1'b1, 32'h0000_0001);
    $display("test message write done");
    slow <= 1'b1;
    repeat (2) msi_q.push_back({hi & 32'hffff_fffc, lo & 32'hffff_fffc, 16'h0, pay[15:0]});
    ev();
    ev();
    ev();
    drain();
    repeat (20) @(posedge i_clock);
    rd(IDX_MSI_CONTROL, 32'h0000_0081);
    $display("test merged events done");
    rd(IDX_IRQ_MASK, 32'h0000_0003);
    xfer(IDX_IRQ_MASK, 1'b1, 32'h0000_0000);
    rd(IDX_IRQ_STATUS, 32'h0000_0001);
    chk(o_irq, 1'b0);
    chk(o_hresp, 1'b0);
    $display("test interrupt mask done");
    i_nrst <= 1'b0;
    repeat (2) @(posedge i_clock);
    i_nrst <= 1'b1;
    @(posedge i_clock);
    rd(IDX_MSI_CONTROL, 32'h0000_0080);
    rd(IDX_MSI_PAYLOAD, 32'h0000_0000);
    rd(IDX_IRQ_STATUS, 32'h0000_0000);
    chk(o_irq, 1'b0);
    $display("test mid-run reset done");
    final_report();
  end
endmodule
